// ===== core/fsp_defs.vh
`ifndef FSP_DEFS_VH
`define FSP_DEFS_VH

// clock and flash pin timing
`define FSP_CLK_NS 20
`define FSP_T_ACC_NS 70
`define FSP_T_WP_NS 35
`define FSP_T_GAP_NS 30
`define FSP_ACC_CYC ((`FSP_T_ACC_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_WP_CYC ((`FSP_T_WP_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_GAP_CYC ((`FSP_T_GAP_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_SYNC_CYC 2

// register offsets (byte addresses)
`define FSP_REG_CTRL 8'h00
`define FSP_REG_POLL_ADDR 8'h04
`define FSP_REG_EXPECT 8'h08
`define FSP_REG_STATUS 8'h0C

// control register fields
`define FSP_CTRL_START 0
`define FSP_CTRL_MODE 1
`define FSP_CTRL_ABORT_RST 2
`define FSP_CTRL_READ_RST 3

// host status register fields
`define FSP_ST_BUSY 0
`define FSP_ST_DONE 1
`define FSP_ST_RES_LO 2
`define FSP_ST_RES_HI 3
`define FSP_ST_LAST_LO 8
`define FSP_ST_LAST_HI 15

// result codes
`define FSP_RES_NONE 2'h0
`define FSP_RES_PASS 2'h1
`define FSP_RES_FAIL 2'h2
`define FSP_RES_ABORT 2'h3

// reset values
`define FSP_POLL_ADDR_RST 32'h0000_0000
`define FSP_EXPECT_RST 8'h00

// flash status byte positions
`define FSP_POLL_BIT 7
`define FSP_TOGGLE_BIT 6
`define FSP_FAIL_BIT 5
`define FSP_WINDOW_BIT 3
`define FSP_ABORT_BIT 1

// flash command sequence
`define FSP_UNLOCK_ADDR1 32'h0000_0555
`define FSP_UNLOCK_ADDR2 32'h0000_02AA
`define FSP_UNLOCK_DATA1 16'h00AA
`define FSP_UNLOCK_DATA2 16'h0055
`define FSP_RESET_DATA 16'h00F0

`endif

// ===== core/fsp_cycle.v
`timescale 1ns/100ps
`default_nettype none
`include "fsp_defs.vh"

module fsp_cycle #(
  parameter ADDR_W = 23,
  parameter DQ_W = 16
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // request from the sequencer
  input wire start,
  input wire wr,
  input wire [ADDR_W-1:0] addr,
  input wire [DQ_W-1:0] wdata,
  output reg done,
  output reg [DQ_W-1:0] rdata,
  // flash pins
  output reg flash_ce_n,
  output reg flash_oe_n,
  output reg flash_we_n,
  output reg [ADDR_W-1:0] flash_addr,
  output reg [DQ_W-1:0] flash_dq_out,
  output reg flash_dq_oe,
  input wire [DQ_W-1:0] flash_dq_in
);

  localparam [1:0] C_IDLE = 2'h0;
  localparam [1:0] C_ACT = 2'h1;
  localparam [1:0] C_HOLD = 2'h2;
  localparam integer RD_CYC = `FSP_ACC_CYC + `FSP_SYNC_CYC - 1;
  localparam integer WP_CYC = `FSP_WP_CYC - 1;
  localparam integer GAP_CYC = `FSP_GAP_CYC - 1;
  localparam [7:0] RD_CNT = RD_CYC[7:0];
  localparam [7:0] WP_CNT = WP_CYC[7:0];
  localparam [7:0] GAP_CNT = GAP_CYC[7:0];

  reg [1:0] state;
  reg [7:0] cnt;
  reg [DQ_W-1:0] dq_s1;
  reg [DQ_W-1:0] dq_s2;

  always @(posedge aclk) begin
    dq_s1 <= flash_dq_in;
    dq_s2 <= dq_s1;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= C_IDLE;
      cnt <= 8'h00;
      done <= 1'b0;
      rdata <= {DQ_W{1'b0}};
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_addr <= {ADDR_W{1'b0}};
      flash_dq_out <= {DQ_W{1'b0}};
      flash_dq_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        C_IDLE: begin
          if (start) begin
            flash_addr <= addr;
            flash_ce_n <= 1'b0;
            if (wr) begin
              flash_we_n <= 1'b0;
              flash_dq_out <= wdata;
              flash_dq_oe <= 1'b1;
              cnt <= WP_CNT;
            end else begin
              // read cycle: chip and output enable low, write enable high
              flash_oe_n <= 1'b0;
              cnt <= RD_CNT;
            end
            state <= C_ACT;
          end
        end
        C_ACT: begin
          if (cnt == 8'h00) begin
            if (flash_we_n) begin
              rdata <= dq_s2;
            end
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_ce_n <= 1'b1;
            cnt <= GAP_CNT;
            state <= C_HOLD;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        C_HOLD: begin
          if (cnt == 8'h00) begin
            flash_dq_oe <= 1'b0;
            done <= 1'b1;
            state <= C_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        default: begin
          state <= C_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== core/fsp_ctrl.v
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "fsp_defs.vh"

module fsp_ctrl #(
  parameter ADDR_W = 23,
  parameter DQ_W = 16
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address and data
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // flash pins
  output wire flash_ce_n,
  output wire flash_oe_n,
  output wire flash_we_n,
  output wire [ADDR_W-1:0] flash_addr,
  output wire [DQ_W-1:0] flash_dq_out,
  output wire flash_dq_oe,
  input wire [DQ_W-1:0] flash_dq_in
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_READ = 3'h1;
  localparam [2:0] S_WAIT_RD = 3'h2;
  localparam [2:0] S_WRITE = 3'h3;
  localparam [2:0] S_WAIT_WR = 3'h4;
  localparam [1:0] SEQ_LAST = 2'h2;

  reg [2:0] state;
  reg mode;
  reg [31:0] poll_addr;
  reg [7:0] expect_byte;
  reg done;
  reg [1:0] result;
  reg [7:0] last_byte;
  reg [7:0] prev_byte;
  reg have_prev;
  reg recheck;
  reg [1:0] seq_idx;
  reg cyc_start;
  reg cyc_wr;
  reg [ADDR_W-1:0] cyc_addr;
  reg [DQ_W-1:0] cyc_wdata;
  wire cyc_done;
  wire [DQ_W-1:0] cyc_rdata;
  wire [7:0] rd_byte;
  wire [31:0] wmask;
  wire wr_go;
  wire busy;
  reg [31:0] seq_addr;
  reg [15:0] seq_data;

  // status sits on the low data byte
  assign rd_byte = cyc_rdata[7:0];
  assign busy = (state != S_IDLE);
  assign wr_go = s_axi_awready & s_axi_awvalid & s_axi_wready & s_axi_wvalid;
  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  // unlock cycles then the reset code; plain reset uses the last step only
  always @* begin
    case (seq_idx)
      2'h0: begin
        seq_addr = `FSP_UNLOCK_ADDR1;
        seq_data = `FSP_UNLOCK_DATA1;
      end
      2'h1: begin
        seq_addr = `FSP_UNLOCK_ADDR2;
        seq_data = `FSP_UNLOCK_DATA2;
      end
      default: begin
        seq_addr = `FSP_UNLOCK_ADDR1;
        seq_data = `FSP_RESET_DATA;
      end
    endcase
  end

  // axi4-lite slave
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        case (s_axi_awaddr)
          `FSP_REG_CTRL, `FSP_REG_POLL_ADDR, `FSP_REG_EXPECT: s_axi_bresp <= 2'h0;
          default: s_axi_bresp <= 2'h2;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        s_axi_rdata <= 32'h0000_0000;
        case (s_axi_araddr)
          `FSP_REG_CTRL: s_axi_rdata[`FSP_CTRL_MODE] <= mode;
          `FSP_REG_POLL_ADDR: s_axi_rdata <= poll_addr;
          `FSP_REG_EXPECT: s_axi_rdata[7:0] <= expect_byte;
          `FSP_REG_STATUS: begin
            s_axi_rdata[`FSP_ST_BUSY] <= busy;
            s_axi_rdata[`FSP_ST_DONE] <= done;
            s_axi_rdata[`FSP_ST_RES_HI:`FSP_ST_RES_LO] <= result;
            s_axi_rdata[`FSP_ST_LAST_HI:`FSP_ST_LAST_LO] <= last_byte;
          end
          default: s_axi_rresp <= 2'h2;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // polling sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= S_IDLE;
      mode <= 1'b0;
      poll_addr <= `FSP_POLL_ADDR_RST;
      expect_byte <= `FSP_EXPECT_RST;
      done <= 1'b0;
      result <= `FSP_RES_NONE;
      last_byte <= 8'h00;
      prev_byte <= 8'h00;
      have_prev <= 1'b0;
      recheck <= 1'b0;
      seq_idx <= 2'h0;
      cyc_start <= 1'b0;
      cyc_wr <= 1'b0;
      cyc_addr <= {ADDR_W{1'b0}};
      cyc_wdata <= {DQ_W{1'b0}};
    end else begin
      cyc_start <= 1'b0;
      if (wr_go && s_axi_awaddr == `FSP_REG_POLL_ADDR) begin
        poll_addr <= (poll_addr & ~wmask) | (s_axi_wdata & wmask);
      end
      if (wr_go && s_axi_awaddr == `FSP_REG_EXPECT && s_axi_wstrb[0]) begin
        expect_byte <= s_axi_wdata[7:0];
      end
      case (state)
        S_IDLE: begin
          if (wr_go && s_axi_awaddr == `FSP_REG_CTRL && s_axi_wstrb[0]) begin
            mode <= s_axi_wdata[`FSP_CTRL_MODE];
            have_prev <= 1'b0;
            recheck <= 1'b0;
            if (s_axi_wdata[`FSP_CTRL_ABORT_RST]) begin
              seq_idx <= 2'h0;
              state <= S_WRITE;
              done <= 1'b0;
            end else if (s_axi_wdata[`FSP_CTRL_READ_RST]) begin
              seq_idx <= SEQ_LAST;
              state <= S_WRITE;
              done <= 1'b0;
            end else if (s_axi_wdata[`FSP_CTRL_START]) begin
              result <= `FSP_RES_NONE;
              state <= S_READ;
              done <= 1'b0;
            end
          end
        end
        S_READ: begin
          // software supplies the programmed address or one in an erasing block
          cyc_addr <= poll_addr[ADDR_W-1:0];
          cyc_wr <= 1'b0;
          cyc_start <= 1'b1;
          state <= S_WAIT_RD;
        end
        S_WAIT_RD: begin
          if (cyc_done) begin
            last_byte <= rd_byte;
            prev_byte <= rd_byte;
            state <= S_READ;
            if (!mode) begin
              // polling bit compared with the true bit of the written data
              if (rd_byte[`FSP_POLL_BIT] == expect_byte[`FSP_POLL_BIT]) begin
                result <= `FSP_RES_PASS;
                done <= 1'b1;
                state <= S_IDLE;
              end else if (recheck) begin
                // only failure and abort flags judged, other bits ignored
                if (rd_byte[`FSP_ABORT_BIT] && !rd_byte[`FSP_FAIL_BIT]) begin
                  result <= `FSP_RES_ABORT;
                  seq_idx <= 2'h0;
                end else begin
                  result <= `FSP_RES_FAIL;
                  seq_idx <= SEQ_LAST;
                end
                state <= S_WRITE;
              end else if (rd_byte[`FSP_FAIL_BIT] || rd_byte[`FSP_ABORT_BIT]) begin
                recheck <= 1'b1;
              end
            end else if (!have_prev) begin
              have_prev <= 1'b1;
            end else if (rd_byte[`FSP_TOGGLE_BIT] == prev_byte[`FSP_TOGGLE_BIT]) begin
              result <= `FSP_RES_PASS;
              done <= 1'b1;
              state <= S_IDLE;
            end else if (recheck) begin
              if (rd_byte[`FSP_ABORT_BIT] && !rd_byte[`FSP_FAIL_BIT]) begin
                result <= `FSP_RES_ABORT;
                seq_idx <= 2'h0;
              end else begin
                result <= `FSP_RES_FAIL;
                seq_idx <= SEQ_LAST;
              end
              state <= S_WRITE;
            end else if (rd_byte[`FSP_FAIL_BIT] || rd_byte[`FSP_ABORT_BIT]) begin
              // two fresh reads decide whether it is still toggling
              recheck <= 1'b1;
              have_prev <= 1'b0;
            end
          end
        end
        S_WRITE: begin
          cyc_addr <= seq_addr[ADDR_W-1:0];
          cyc_wdata <= seq_data;
          cyc_wr <= 1'b1;
          cyc_start <= 1'b1;
          state <= S_WAIT_WR;
        end
        S_WAIT_WR: begin
          if (cyc_done) begin
            if (seq_idx == SEQ_LAST) begin
              done <= 1'b1;
              state <= S_IDLE;
            end else begin
              seq_idx <= seq_idx + 2'h1;
              state <= S_WRITE;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  fsp_cycle #(
    .ADDR_W(ADDR_W),
    .DQ_W(DQ_W)
  ) u_cycle (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(cyc_start),
    .wr(cyc_wr),
    .addr(cyc_addr),
    .wdata(cyc_wdata),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in)
  );

endmodule
`default_nettype wire

// ===== sim/fsp_ctrl_props.sv
`timescale 1ns/100ps
`default_nettype none
module fsp_ctrl_props #(
  parameter ADDR_W = 23
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // flash pins
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic flash_dq_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_read_strobes: assert property (
    !flash_oe_n |-> !flash_ce_n && flash_we_n && !flash_dq_oe) else $error("bad read strobes");
  a_write_strobes: assert property (
    !flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe) else $error("bad write strobes");
  a_read_length: assert property (
    $fell(flash_oe_n) |-> (!flash_oe_n)[*6] ##1 flash_oe_n) else $error("bad read length");
  a_write_length: assert property (
    $fell(flash_we_n) |-> (!flash_we_n)[*2] ##1 flash_we_n) else $error("bad write length");
  a_strobe_gap: assert property (
    $rose(flash_ce_n) |-> flash_ce_n[*2]) else $error("gap too short");
  a_read_addr_held: assert property (
    !flash_oe_n && !$past(flash_oe_n) |-> $stable(flash_addr)) else $error("address moved");
  a_write_answer: assert property (
    $rose(s_axi_awvalid) && s_axi_wvalid |-> ##1 s_axi_awready && s_axi_wready ##1 s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (
    $rose(s_axi_arvalid) |-> !s_axi_rvalid ##1 s_axi_arready ##1 s_axi_rvalid)
    else $error("read answer late");
  a_bresp_held: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_held: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  c_flash_read: cover property ($fell(flash_oe_n));
  c_flash_write: cover property ($fell(flash_we_n));
  c_read_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule
`default_nettype wire

// ===== sim/fsp_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module fsp_flash_model (
  // flash pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [22:0] addr,
  input wire logic [15:0] dq_out,
  output logic [15:0] dq_in,
  // scenario control
  input wire logic load,
  input wire logic [2:0] op,
  input wire logic [7:0] data,
  input wire logic [7:0] reads,
  output int n_reset,
  output int n_abort
);
  localparam IDLE = 0, PROG = 1, ERASE = 2, FAIL = 3, ABRT = 4, SUSP = 5;
  logic [2:0] st = 3'h0;
  logic [7:0] val = 8'hFF;
  logic [7:0] left = 8'h00;
  logic [7:0] s;
  logic [39:0] hist = 40'h0;
  logic t6 = 1'b0;
  logic t2 = 1'b0;
  logic blk = 1'b0;
  logic seen = 1'b0;
  logic rd = 1'b0;
  initial begin
    dq_in = 16'h0000;
    n_reset = 0;
    n_abort = 0;
  end
  always @(posedge load) begin
    st = op;
    val = data;
    left = reads;
    seen = 1'b0;
  end
  always @(negedge oe_n) begin
    #1;
    if (!ce_n && we_n) begin
      rd = 1'b1;
      blk = addr[22:16] == 7'h01;
      s = {1'b0, t6, 6'h00};
      case (st)
        PROG: s[7] = ~val[7];
        ERASE: s[3:2] = {seen, blk & t2};
        FAIL: s[7:5] = {~val[7], t6, 1'b1};
        ABRT: s[7:1] = {~val[7], t6, 4'h0, 1'b1};
        SUSP: s = blk ? {5'h10, t2, 2'h0} : val;
        default: s = val;
      endcase
      dq_in = {8'h00, s};
    end
  end
  always @(posedge oe_n) if (rd) begin
    rd = 1'b0;
    if (st != IDLE && st != SUSP) t6 = ~t6;
    if ((st == ERASE || st == SUSP) && blk) t2 = ~t2;
    seen = 1'b1;
    if (left > 0) left--;
    if (left == 0 && (st == PROG || st == ERASE)) st = IDLE;
    dq_in = ~dq_in;
  end
  always @(negedge we_n) begin
    #1;
    if (!ce_n) begin
      hist = {hist[19:0], addr[11:0], dq_out[7:0]};
      if (hist[19:0] == 20'h555F0) begin
        if (hist[39:20] == 20'h2AA55) n_abort++;
        else n_reset++;
        st = IDLE;
        hist = 40'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/test_fsp_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "fsp_defs.vh"
module test_fsp_ctrl;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe;
  logic [22:0] flash_addr;
  logic [15:0] flash_dq_out, flash_dq_in;
  logic load = 0;
  logic [2:0] op = 3'h0;
  logic [7:0] data = 8'h00, reads = 8'h00;
  int n_reset, n_abort, mismatches = 0, checks = 0;
  always #10 aclk = ~aclk;
  fsp_ctrl #(.ADDR_W(23), .DQ_W(16)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flash_ce_n, .flash_oe_n, .flash_we_n,
    .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in);
  fsp_flash_model u_flash (.ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
    .addr(flash_addr), .dq_out(flash_dq_out), .dq_in(flash_dq_in), .load, .op, .data, .reads,
    .n_reset, .n_abort);
  task results;
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 3000) begin
      cmp("wait bound", 32'h0, 32'h1);
      results();
    end
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw, w;
    n = 0;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      tick(n);
      if (aw && w) s_axi_bready <= 1'b1;
      if (s_axi_awready && !aw) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar;
    n = 0;
    ar = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      tick(n);
      if (ar) s_axi_rready <= 1'b1;
      if (s_axi_arready && !ar) begin
        ar = 1;
        s_axi_arvalid <= 1'b0;
      end
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // loads the far side, starts a poll and waits for done
  task run_poll(input logic [2:0] o, input logic [7:0] dat, rd, input logic [31:0] pa, ctl, ex,
    output logic [31:0] st);
    int n;
    logic [1:0] r;
    n = 0;
    op <= o;
    data <= dat;
    reads <= rd;
    load <= 1'b1;
    axi_wr(`FSP_REG_POLL_ADDR, pa, r);
    load <= 1'b0;
    axi_wr(`FSP_REG_EXPECT, ex, r);
    axi_wr(`FSP_REG_CTRL, ctl, r);
    do begin
      axi_rd(`FSP_REG_STATUS, st, r);
      n++;
      if (n > 300) begin
        cmp("poll bound", 32'h0, 32'h1);
        results();
      end
    end while (st[`FSP_ST_DONE] !== 1'b1);
  endtask
  task s_regs;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(`FSP_REG_POLL_ADDR, d, r);
    cmp("poll addr reset", `FSP_POLL_ADDR_RST, d);
    axi_rd(`FSP_REG_EXPECT, d, r);
    cmp("expect reset", {24'h0, `FSP_EXPECT_RST}, d);
    axi_rd(`FSP_REG_STATUS, d, r);
    cmp("status reset", 32'h0, d);
    axi_rd(8'h10, d, r);
    cmp("unmapped rd", 32'h2, {30'h0, r});
    cmp("unmapped rdata", 32'h0, d);
    axi_wr(8'h14, 32'hFFFF_FFFF, r);
    cmp("unmapped bresp", 32'h2, {30'h0, r});
    axi_wr(`FSP_REG_POLL_ADDR, 32'h0001_2345, r);
    axi_rd(`FSP_REG_POLL_ADDR, d, r);
    cmp("poll addr rw", 32'h0001_2345, d);
  endtask
  task s_program;
    logic [31:0] st;
    run_poll(3'h1, 8'h3A, 8'h03, 32'h0000_0123, 32'h1, 32'h3A, st);
    cmp("program status", {16'h0, 8'h3A, 4'h0, `FSP_RES_PASS, 2'b10}, st);
  endtask
  task s_erase;
    logic [31:0] st, d;
    logic [1:0] r;
    run_poll(3'h2, 8'hFF, 8'h04, 32'h0001_0000, 32'h3, 32'h80, st);
    cmp("erase status", {16'h0, 8'hFF, 4'h0, `FSP_RES_PASS, 2'b10}, st);
    axi_rd(`FSP_REG_CTRL, d, r);
    cmp("ctrl mode", 32'h2, d & 32'h2);
  endtask
  task s_fail;
    logic [31:0] st;
    int n0;
    n0 = n_reset;
    run_poll(3'h3, 8'h80, 8'h00, 32'h0000_0200, 32'h1, 32'h80, st);
    cmp("fail result", {`FSP_RES_FAIL, 2'b10}, st[3:0]);
    cmp("read reset sent", n0 + 1, n_reset);
  endtask
  task s_abort;
    logic [31:0] st;
    int n0;
    n0 = n_abort;
    run_poll(3'h4, 8'h80, 8'h00, 32'h0000_0300, 32'h1, 32'h80, st);
    cmp("abort result", {`FSP_RES_ABORT, 2'b10}, st[3:0]);
    cmp("abort reset sent", n0 + 1, n_abort);
  endtask
  task s_suspend;
    logic [31:0] st;
    run_poll(3'h5, 8'h5C, 8'h00, 32'h0001_0040, 32'h3, 32'h80, st);
    cmp("suspend poll", {1'b1, 4'h0, `FSP_RES_PASS, 2'b10}, {st[15], st[7:0]});
    run_poll(3'h5, 8'h5C, 8'h00, 32'h0000_0040, 32'h1, 32'h5C, st);
    cmp("suspend array", {16'h0, 8'h5C, 4'h0, `FSP_RES_PASS, 2'b10}, st);
  endtask
  // software-issued recovery commands; abort-and-reset outranks plain reset
  task s_resets;
    logic [31:0] st;
    int n0, n1;
    n0 = n_reset;
    n1 = n_abort;
    run_poll(3'h0, 8'hFF, 8'h00, 32'h0000_0000, 32'h8, 32'h80, st);
    cmp("read reset cmd", n0 + 1, n_reset);
    cmp("read reset status", {`FSP_RES_PASS, 2'b10}, st[3:0]);
    run_poll(3'h0, 8'hFF, 8'h00, 32'h0000_0000, 32'hC, 32'h80, st);
    cmp("abort reset cmd", n1 + 1, n_abort);
    cmp("abort reset only", n0 + 1, n_reset);
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    s_regs();
    s_program();
    s_erase();
    s_fail();
    s_abort();
    s_suspend();
    s_resets();
    results();
  end
endmodule
bind fsp_ctrl fsp_ctrl_props #(.ADDR_W(ADDR_W)) u_props (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .flash_ce_n,
  .flash_oe_n, .flash_we_n, .flash_addr, .flash_dq_oe);
`default_nettype wire
